// >>> mac_unit.sv
// Multiply-accumulate datapath with accumulators, status and trap requests.
// Assumes the decoder presents one operation per op_valid_i cycle and that
// software reaches the control and status registers over APB.
`timescale 1ns/1ps
module mac_unit (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [mac_pkg::ADR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic op_valid_i,
   input wire mac_pkg::mac_op_type op_code_i,
   input wire logic acc_sel_i,
   input wire logic [15:0] op_b_i,
   input wire logic [15:0] op_c_i,
   input wire logic [39:0] load_data_i,
   input wire logic signed [5:0] shift_i,
   input wire logic mul_b_signed_i,
   input wire logic mul_c_signed_i,
   input wire logic mul_byte_i,
   output logic [31:0] mul_result_o,
   output logic mul_valid_o,
   output logic [39:0] acc_a_o,
   output logic [39:0] acc_b_o,
   output logic [15:0] cpu_status_o,
   output logic ovf_a_trap_o,
   output logic ovf_b_trap_o,
   output logic catastrophic_trap_o
);
   import mac_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic signed [16:0] widen(input logic [15:0] v, input logic sgn);
      return {sgn & v[15], v};
   endfunction : widen

   function automatic logic [39:0] shift40(input logic [39:0] v, input logic signed [5:0] s);
      logic [5:0] mag;
      mag = s[5] ? 6'(-s) : 6'(s);
      // Positive counts shift right arithmetically, negative ones left.
      if (s[5]) begin
         return v << mag;
      end
      return 40'($signed(v) >>> mag);
   endfunction : shift40

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [39:0] acc_a;
   logic [39:0] acc_b;
   logic [15:0] core_control;
   logic [15:0] interrupt_control_one;
   logic acc_a_overflow;
   logic acc_b_overflow;
   logic acc_a_clipped;
   logic acc_b_clipped;
   logic any_acc_overflow;
   logic any_acc_clipped;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic apb_access;
   logic apb_hit;
   logic apb_wr;
   logic [15:0] rd_mux;

   assign apb_access = psel_i & penable_i;
   assign pready_o = 1'b1;
   assign apb_wr = apb_access & pwrite_i & apb_hit;
   assign pslverr_o = apb_access & ~apb_hit;

   always_comb begin
      apb_hit = 1'b1;
      rd_mux = 16'h0000;
      unique case (paddr_i)
         OFS_STATUS: rd_mux = cpu_status_o;
         OFS_CORE: rd_mux = core_control;
         OFS_INTCTL: rd_mux = interrupt_control_one;
         OFS_ACCUMULATOR_A_L: rd_mux = acc_a[15:0];
         OFS_ACCUMULATOR_A_H: rd_mux = acc_a[31:16];
         OFS_ACCUMULATOR_A_U: rd_mux = {8'h00, acc_a[39:32]};
         OFS_ACCUMULATOR_B_L: rd_mux = acc_b[15:0];
         OFS_ACCUMULATOR_B_H: rd_mux = acc_b[31:16];
         OFS_ACCUMULATOR_B_U: rd_mux = {8'h00, acc_b[39:32]};
         default: apb_hit = 1'b0;
      endcase
   end

   // Read data is caught in the setup cycle so it leaves a flip-flop.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i & ~penable_i) begin
         prdata_o <= {16'h0000, rd_mux};
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         core_control <= CORE_RST;
         interrupt_control_one <= INTCTL_RST;
      end else if (apb_wr) begin
         if (paddr_i == OFS_CORE) begin
            core_control <= pwdata_i[15:0];
         end
         if (paddr_i == OFS_INTCTL) begin
            interrupt_control_one <= pwdata_i[15:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Multiplier operands
   // ---------------------------------------------------------------
   mac_mult_if mif ();
   mac_multiplier u_mult (.m(mif));

   logic dsp_signed;
   logic [16:0] ed_diff;
   logic [15:0] mul_b16;
   logic [15:0] mul_c16;

   assign dsp_signed = ~core_control[CC_US];
   assign ed_diff = {op_b_i[15], op_b_i} - {op_c_i[15], op_c_i};
   // Byte operands are extended to a word by the variant's signedness.
   assign mul_b16 = mul_byte_i ? {{8{mul_b_signed_i & op_b_i[7]}}, op_b_i[7:0]} : op_b_i;
   assign mul_c16 = mul_byte_i ? {{8{mul_c_signed_i & op_c_i[7]}}, op_c_i[7:0]} : op_c_i;

   always_comb begin
      unique case (op_code_i)
         MAC_OP_ED, MAC_OP_ACCUMULATE_EUCLID_DISTANCE: begin
            mif.opa = ed_diff;
            mif.opb = ed_diff;
         end
         MAC_OP_MUL: begin
            mif.opa = widen(mul_b16, mul_b_signed_i);
            mif.opb = widen(mul_c16, mul_c_signed_i);
         end
         default: begin
            mif.opa = widen(op_b_i, dsp_signed);
            mif.opb = widen(op_c_i, dsp_signed);
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Integer product result
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mul_result_o <= 32'h0000_0000;
         mul_valid_o <= 1'b0;
      end else begin
         mul_valid_o <= op_valid_i & (op_code_i == MAC_OP_MUL);
         if (op_valid_i & (op_code_i == MAC_OP_MUL)) begin
            mul_result_o <= mul_byte_i ? {16'h0000, mif.prod[15:0]} : mif.prod[31:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // 40-bit adder/subtractor and saturation
   // ---------------------------------------------------------------
   logic dsp_go;
   logic [39:0] src;
   logic [39:0] prod40;
   logic [39:0] shifted;
   logic [40:0] base41;
   logic [40:0] add41;
   logic neg;
   logic [40:0] sum41;
   logic ovf39;
   logic ovf31;
   logic sat_en;
   logic wide_sat;
   logic clip_evt;
   logic [39:0] result;
   logic ovf_new;

   assign dsp_go = op_valid_i & (op_code_i != MAC_OP_MUL) & (op_code_i != MAC_OP_NONE);
   assign src = acc_sel_i ? acc_b : acc_a;
   assign shifted = shift40(load_data_i, shift_i);

   always_comb begin
      prod40 = {{6{mif.prod[33]}}, mif.prod};
      if (~core_control[CC_IF]) begin
         prod40 = {prod40[38:0], 1'b0};
      end
   end

   always_comb begin
      base41 = {src[39], src};
      add41 = {prod40[39], prod40};
      neg = 1'b0;
      unique case (op_code_i)
         MAC_OP_MAC, MAC_OP_ACCUMULATE_EUCLID_DISTANCE: neg = 1'b0;
         MAC_OP_MSC: neg = 1'b1;
         MAC_OP_MPY, MAC_OP_ED: base41 = 41'h000_0000_0000;
         MAC_OP_MPYN: begin
            base41 = 41'h000_0000_0000;
            neg = 1'b1;
         end
         MAC_OP_ADD: add41 = {shifted[39], shifted};
         MAC_OP_LAC: begin
            base41 = 41'h000_0000_0000;
            add41 = {shifted[39], shifted};
         end
         MAC_OP_MUL, MAC_OP_NONE: neg = 1'b0;
      endcase
      sum41 = neg ? base41 - add41 : base41 + add41;
   end

   assign ovf39 = sum41[40] ^ sum41[39];
   assign ovf31 = ~((&sum41[40:31]) | ~(|sum41[40:31]));
   assign sat_en = acc_sel_i ? core_control[CC_ACC_B_CLIP_ENABLE] : core_control[CC_ACC_A_CLIP_ENABLE];
   assign wide_sat = core_control[CC_CLIP_WIDTH_SELECT];
   // Without saturation a bit-39 overflow has destroyed the sign.
   assign clip_evt = (sat_en & ~wide_sat) ? ovf31 : ovf39;

   always_comb begin
      result = sum41[39:0];
      if (sat_en & wide_sat & ovf39) begin
         result = sum41[40] ? SAT39_NEG : SAT39_POS;
      end else if (sat_en & ~wide_sat & ovf31) begin
         result = sum41[40] ? SAT31_NEG : SAT31_POS;
      end
   end

   // Guard bits that are not a copy of bit 31 mean the value left Q.31.
   assign ovf_new = ~((&result[39:31]) | ~(|result[39:31]));

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         acc_a <= ACC_RST;
         acc_b <= ACC_RST;
      end else if (dsp_go) begin
         if (acc_sel_i) begin
            acc_b <= result;
         end else begin
            acc_a <= result;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   logic st_wr;
   logic clr_sa;
   logic clr_sb;
   logic set_sa;
   logic set_sb;

   assign st_wr = apb_wr & (paddr_i == OFS_STATUS);
   assign clr_sa = st_wr & (~pwdata_i[ST_SA] | ~pwdata_i[ST_SAB]);
   assign clr_sb = st_wr & (~pwdata_i[ST_SB] | ~pwdata_i[ST_SAB]);
   assign set_sa = dsp_go & ~acc_sel_i & clip_evt;
   assign set_sb = dsp_go & acc_sel_i & clip_evt;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         acc_a_overflow <= 1'b0;
         acc_b_overflow <= 1'b0;
      end else if (dsp_go) begin
         if (acc_sel_i) begin
            acc_b_overflow <= ovf_new;
         end else begin
            acc_a_overflow <= ovf_new;
         end
      end
   end

   // A clipping event in the clearing cycle keeps the flag set.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         acc_a_clipped <= 1'b0;
         acc_b_clipped <= 1'b0;
      end else begin
         acc_a_clipped <= (acc_a_clipped & ~clr_sa) | set_sa;
         acc_b_clipped <= (acc_b_clipped & ~clr_sb) | set_sb;
      end
   end

   assign any_acc_overflow = acc_a_overflow | acc_b_overflow;
   assign any_acc_clipped = acc_a_clipped | acc_b_clipped;
   assign cpu_status_o = {acc_a_overflow, acc_b_overflow, acc_a_clipped, acc_b_clipped,
                          any_acc_overflow, any_acc_clipped, 10'h000};
   assign acc_a_o = acc_a;
   assign acc_b_o = acc_b;

   // ---------------------------------------------------------------
   // Trap requests
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ovf_a_trap_o <= 1'b0;
         ovf_b_trap_o <= 1'b0;
         catastrophic_trap_o <= 1'b0;
      end else begin
         ovf_a_trap_o <= dsp_go & ~acc_sel_i & ovf_new & ~acc_a_overflow
                         & interrupt_control_one[IC_ACC_A_OVERFLOW_TRAP_ENABLE];
         ovf_b_trap_o <= dsp_go & acc_sel_i & ovf_new & ~acc_b_overflow
                         & interrupt_control_one[IC_ACC_B_OVERFLOW_TRAP_ENABLE];
         catastrophic_trap_o <= ((set_sa & ~acc_a_clipped) | (set_sb & ~acc_b_clipped))
                                & ~sat_en & interrupt_control_one[IC_CATASTROPHIC_TRAP_ENABLE];
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   clear_sab_a: assert property (st_wr & ~pwdata_i[ST_SAB] & ~set_sa & ~set_sb
      |=> ~cpu_status_o[ST_SA] & ~cpu_status_o[ST_SB] & ~cpu_status_o[ST_SAB])
      else $error("clearing any_acc_clipped left a clipped flag set");

   or_flags_a: assert property (cpu_status_o[ST_OAB] == (acc_a_overflow | acc_b_overflow)
      && cpu_status_o[ST_SAB] == (acc_a_clipped | acc_b_clipped))
      else $error("combined status flags disagree");

   sticky_clip_a: assert property (acc_a_clipped & ~clr_sa |=> acc_a_clipped)
      else $error("acc_a_clipped dropped without a clear");

   trap_pulse_a: assert property (ovf_a_trap_o |=> ~ovf_a_trap_o)
      else $error("overflow trap longer than one cycle");

   trap_cause_a: assert property (ovf_a_trap_o |-> acc_a_overflow && !$past(acc_a_overflow)
      && interrupt_control_one[IC_ACC_A_OVERFLOW_TRAP_ENABLE])
      else $error("overflow trap without new enabled flag");

   sat39_pos_a: assert property (dsp_go & ~acc_sel_i & core_control[CC_ACC_A_CLIP_ENABLE] & wide_sat
      & ovf39 & ~sum41[40] |=> acc_a == SAT39_POS ##1 acc_a_clipped | clr_sa)
      else $error("39-bit saturation did not load the positive limit");

   sat31_ovf_a: assert property (dsp_go & ~acc_sel_i & core_control[CC_ACC_A_CLIP_ENABLE] & ~wide_sat
      |=> ~acc_a_overflow)
      else $error("overflow flag set under 31-bit saturation");

   integer_product_unsigned_a: assert property (op_valid_i & (op_code_i == MAC_OP_MUL) & ~mul_byte_i
      & ~mul_b_signed_i & ~mul_c_signed_i
      |=> mul_valid_o && mul_result_o == 32'($past(op_b_i) * $past(op_c_i)))
      else $error("unsigned integer product wrong");

   frac_mpy_a: assert property (dsp_go & (op_code_i == MAC_OP_MPY) & ~acc_sel_i
      & ~core_control[CC_IF] |=> acc_a[0] == 1'b0)
      else $error("fractional product low bit not cleared");

   apb_err_a: assert property (apb_access & ~apb_hit |-> pslverr_o)
      else $error("unmapped access not flagged");

   mac_b_c: cover property (dsp_go & acc_sel_i & (op_code_i == MAC_OP_MAC));
   clip_set_c: cover property (set_sa ##1 acc_a_clipped);
   sab_clear_c: cover property (any_acc_clipped ##1 clr_sa & clr_sb ##1 ~any_acc_clipped);
   cat_trap_c: cover property (catastrophic_trap_o);
endmodule : mac_unit

// >>> mac_pkg.sv
// Constants and types of the multiply-accumulate datapath.
// Assumes one core clock, a synchronous reset and an APB register port.
// Operation
// - six multiply forms write one accumulator
// - unsigned_dsp_mult makes DSP operands zero-extended, except the signed ED differences
// - unsigned_dsp_mult ignored by integer products
// - byte gives 16-bit, word 32-bit result
// - integer products support all sign pairings
// - DSP multiply fractional or integer, no mixing
// - 40-bit adder sign-extends signed products
// - one accumulator is source and destination
// - add and load operands optionally shifted
// - negate one adder input for subtract, negate
// - overflow flags at status bits 15, 14
// - clipped flags at status bits 13, 12
// - OR flags at status bits 11, 10
// - clearing any_acc_clipped clears both clipped flags
// - overflow flags read-only, updated every pass
// - enabled overflow flag raises arithmetic trap
// - clipped flags sticky until software clears
// - clipped when bit 31 or 39 overflows
// - unsaturated clip is catastrophic, optional trap
// - fractional mode shifts product left one
// - operands widened to 17 bits before multiply
// - 39-bit saturation loads 40-bit limits
// - 31-bit saturation loads 32-bit limits
package mac_pkg;
   localparam int ACC_W = 40;
   localparam int OPD_W = 16;
   localparam int MUL_W = 17;
   localparam int PRD_W = 34;
   localparam int ADR_W = 8;

   // Register byte offsets on the APB port.
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CORE = 8'h04;
   localparam logic [7:0] OFS_INTCTL = 8'h08;
   localparam logic [7:0] OFS_ACCUMULATOR_A_L = 8'h0C;
   localparam logic [7:0] OFS_ACCUMULATOR_A_H = 8'h10;
   localparam logic [7:0] OFS_ACCUMULATOR_A_U = 8'h14;
   localparam logic [7:0] OFS_ACCUMULATOR_B_L = 8'h18;
   localparam logic [7:0] OFS_ACCUMULATOR_B_H = 8'h1C;
   localparam logic [7:0] OFS_ACCUMULATOR_B_U = 8'h20;

   // Field positions.
   localparam int ST_OA = 15;
   localparam int ST_OB = 14;
   localparam int ST_SA = 13;
   localparam int ST_SB = 12;
   localparam int ST_OAB = 11;
   localparam int ST_SAB = 10;
   localparam int CC_US = 12;
   localparam int CC_ACC_A_CLIP_ENABLE = 7;
   localparam int CC_ACC_B_CLIP_ENABLE = 6;
   localparam int CC_CLIP_WIDTH_SELECT = 4;
   localparam int CC_IF = 0;
   localparam int IC_ACC_A_OVERFLOW_TRAP_ENABLE = 10;
   localparam int IC_ACC_B_OVERFLOW_TRAP_ENABLE = 9;
   localparam int IC_CATASTROPHIC_TRAP_ENABLE = 8;

   // Values after reset; bit 0 clear selects fractional multiply.
   localparam logic [15:0] CORE_RST = 16'h0000;
   localparam logic [15:0] INTCTL_RST = 16'h0000;
   localparam logic [39:0] ACC_RST = 40'h00_0000_0000;

   // Saturation limits.
   localparam logic [39:0] SAT39_POS = 40'h7F_FFFF_FFFF;
   localparam logic [39:0] SAT39_NEG = 40'h80_0000_0000;
   localparam logic [39:0] SAT31_POS = 40'h00_7FFF_FFFF;
   localparam logic [39:0] SAT31_NEG = 40'hFF_8000_0000;

   typedef enum logic [3:0] {
      MAC_OP_MAC, MAC_OP_MSC, MAC_OP_MPY, MAC_OP_MPYN, MAC_OP_ED,
      MAC_OP_ACCUMULATE_EUCLID_DISTANCE, MAC_OP_ADD, MAC_OP_LAC, MAC_OP_MUL, MAC_OP_NONE
   } mac_op_type;
endpackage : mac_pkg

// >>> mac_mult_if.sv
// Operand and product wires between the datapath and the multiplier.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface mac_mult_if;
   logic signed [16:0] opa;
   logic signed [16:0] opb;
   logic signed [33:0] prod;
   modport user (output opa, output opb, input prod);
   modport unit (input opa, input opb, output prod);
endinterface : mac_mult_if

// >>> mac_multiplier.sv
// Shared 17-by-17 signed multiplier.
// Assumes operands arrive already widened to 17 bits.
`timescale 1ns/1ps
module mac_multiplier (
   mac_mult_if.unit m
);
   import mac_pkg::*;
   // A 17-bit signed operand covers both signed and unsigned 16-bit values.
   assign m.prod = m.opa * m.opb;
endmodule : mac_multiplier

// >>> mac_trap_sink.sv
// Interrupt controller stand-in that counts trap request cycles.
// Assumes the trap requests are synchronous to clk_i.
`timescale 1ns/1ps
module mac_trap_sink (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [2:0] trap_i,
   output logic [7:0] n_a_o,
   output logic [7:0] n_b_o,
   output logic [7:0] n_c_o
);
   // Counting high cycles, not edges, exposes a request that lingers.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         n_a_o <= 8'h00;
         n_b_o <= 8'h00;
         n_c_o <= 8'h00;
      end else begin
         n_a_o <= n_a_o + 8'(trap_i[0]);
         n_b_o <= n_b_o + 8'(trap_i[1]);
         n_c_o <= n_c_o + 8'(trap_i[2]);
      end
   end
endmodule : mac_trap_sink

// >>> mac_unit_bench.sv
// Self-checking bench of the multiply-accumulate unit.
// Assumes an APB slave that may add wait states and a trap counting partner.
`timescale 1ns/1ps
module mac_unit_bench;
   import mac_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, mul_res;
   logic pready, pslverr, mul_valid, ova, ovb, cat;
   logic op_valid = 1'b0, acc_sel = 1'b0, sb_s = 1'b0, sc_s = 1'b0, byt = 1'b0;
   mac_op_type op_code = MAC_OP_NONE;
   logic [15:0] b = 16'h0000, c = 16'h0000, st;
   logic [39:0] ld = 40'h0, acc_a, acc_b, ea, eb;
   logic signed [5:0] sh = 6'h00;
   logic [7:0] na, nb, nc;
   logic [39:0] rq[$];
   logic [39:0] mq[$];
   logic [31:0] seed = 32'h0000_2E97;
   int n_fail = 0;
   int n_compared = 0;

   mac_unit dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .op_valid_i(op_valid), .op_code_i(op_code),
      .acc_sel_i(acc_sel), .op_b_i(b), .op_c_i(c), .load_data_i(ld), .shift_i(sh),
      .mul_b_signed_i(sb_s), .mul_c_signed_i(sc_s), .mul_byte_i(byt),
      .mul_result_o(mul_res), .mul_valid_o(mul_valid), .acc_a_o(acc_a), .acc_b_o(acc_b),
      .cpu_status_o(st), .ovf_a_trap_o(ova), .ovf_b_trap_o(ovb),
      .catastrophic_trap_o(cat));
   mac_trap_sink sink (.clk_i(clk_i), .reset_i(reset_i), .trap_i({cat, ovb, ova}),
      .n_a_o(na), .n_b_o(nb), .n_c_o(nc));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic close_out();
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [39:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d});
   endtask : wr

   task automatic rdacc(input logic s, input logic [39:0] e);
      logic [7:0] a;
      a = s ? OFS_ACCUMULATOR_B_L : OFS_ACCUMULATOR_A_L;
      rd(a, {24'h0, e[15:0]});
      rd(a + 8'h04, {24'h0, e[31:16]});
      rd(a + 8'h08, {32'h0, e[39:32]});
      chk("acc_out", e, s ? acc_b : acc_a);
   endtask : rdacc

   task automatic op(input mac_op_type o, input logic s, input logic [15:0] x, y,
      input logic [39:0] l, input logic [5:0] k);
      @(posedge clk_i);
      op_valid <= 1'b1;
      op_code <= o;
      acc_sel <= s;
      b <= x;
      c <= y;
      ld <= l;
      sh <= k;
      @(posedge clk_i);
      op_valid <= 1'b0;
   endtask : op

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function automatic logic [39:0] dsp(input logic [15:0] x, y, input logic us, im);
      logic signed [39:0] p;
      p = $signed({~us & x[15], x}) * $signed({~us & y[15], y});
      return im ? p : p << 1;
   endfunction : dsp

   function automatic logic [39:0] sq(input logic [15:0] x, y);
      logic signed [39:0] d;
      d = $signed(x) - $signed(y);
      return d * d;
   endfunction : sq

   function automatic logic ovf(input logic [39:0] a);
      return !((&a[39:31]) || !(|a[39:31]));
   endfunction : ovf

   function automatic logic [39:0] stat(input logic [39:0] a, e, input logic sa, sbt);
      return {24'h0, ovf(a), ovf(e), sa, sbt, ovf(a) | ovf(e), sa | sbt, 10'h000};
   endfunction : stat

   always @(posedge clk_i) begin
      if (mul_valid) chk("mul_result", mq.pop_front(), {8'h00, mul_res});
      if (psel && penable && pready && !pwrite) chk("prdata", rq.pop_front(), {8'h00, prdata});
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [15:0] x, y;
      logic [39:0] p, t;
      mac_op_type o;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(OFS_STATUS, 40'h0);
      rd(OFS_CORE, {24'h0, CORE_RST});
      rd(8'h40, 40'h0);
      chk("pslverr", 40'h1, {39'h0, last_err});
      op(MAC_OP_MPY, 1'b0, 16'h4001, 16'hC002, 40'h0, 6'h00);
      rdacc(1'b0, dsp(16'h4001, 16'hC002, 1'b0, 1'b0));
      wr(OFS_CORE, 16'h0001);
      ea = 40'h0;
      eb = 40'h0;
      op(MAC_OP_LAC, 1'b0, 16'h0000, 16'h0000, 40'h0, 6'h00);
      op(MAC_OP_LAC, 1'b1, 16'h0000, 16'h0000, 40'h0, 6'h00);
      for (int i = 0; i < 24; i++) begin
         r = xs();
         o = mac_op_type'(4'(r[18:16] % 3'h6));
         x = r[15:0];
         y = xs();
         if (r[22:20] == 3'h0) y = x;
         p = (o inside {MAC_OP_ED, MAC_OP_ACCUMULATE_EUCLID_DISTANCE}) ? sq(x, y) : dsp(x, y, 1'b0, 1'b1);
         t = r[19] ? eb : ea;
         if (o == MAC_OP_MSC) t = t - p;
         else if (o == MAC_OP_MPYN) t = -p;
         else if (o inside {MAC_OP_MPY, MAC_OP_ED}) t = p;
         else t = t + p;
         if (r[19]) eb = t;
         else ea = t;
         op(o, r[19], x, y, 40'h0, 6'h00);
      end
      rdacc(1'b0, ea);
      rdacc(1'b1, eb);
      rd(OFS_STATUS, stat(ea, eb, 1'b0, 1'b0));
      wr(OFS_CORE, 16'h1001);
      op(MAC_OP_MPY, 1'b1, 16'hFFFF, 16'hFFFF, 40'h0, 6'h00);
      rdacc(1'b1, dsp(16'hFFFF, 16'hFFFF, 1'b1, 1'b1));
      for (int i = 0; i < 8; i++) begin
         r = xs();
         x = i[2] ? {9'h000, r[6:0]} : r[15:0];
         y = i[2] ? {9'h000, r[22:16]} : r[31:16];
         sb_s <= i[0];
         sc_s <= i[1];
         byt <= i[2];
         t = $signed({i[0] & x[15], x}) * $signed({i[1] & y[15], y});
         mq.push_back(i[2] ? {24'h0, t[15:0]} : {8'h00, t[31:0]});
         op(MAC_OP_MUL, 1'b0, x, y, 40'h0, 6'h00);
      end
      wr(OFS_CORE, 16'h0081);
      op(MAC_OP_LAC, 1'b0, 16'h0000, 16'h0000, 40'h00_7FFF_0000, 6'h00);
      op(MAC_OP_ADD, 1'b0, 16'h0000, 16'h0000, 40'h100, 6'h30);
      rdacc(1'b0, SAT31_POS);
      wr(OFS_CORE, 16'h0051);
      op(MAC_OP_LAC, 1'b1, 16'h0000, 16'h0000, 40'hFE_0000_0000, 6'h01);
      op(MAC_OP_ADD, 1'b1, 16'h0000, 16'h0000, 40'h80_0000_0000, 6'h00);
      rdacc(1'b1, SAT39_NEG);
      rd(OFS_STATUS, stat(SAT31_POS, SAT39_NEG, 1'b1, 1'b1));
      wr(OFS_STATUS, 16'h3000);
      rd(OFS_STATUS, stat(SAT31_POS, SAT39_NEG, 1'b0, 1'b0));
      wr(OFS_CORE, 16'h0001);
      wr(OFS_INTCTL, 16'h0700);
      rd(OFS_INTCTL, 40'h700);
      op(MAC_OP_LAC, 1'b1, 16'h0000, 16'h0000, 40'h0, 6'h00);
      op(MAC_OP_LAC, 1'b0, 16'h0000, 16'h0000, 40'h7F_FFFF_FFFF, 6'h00);
      op(MAC_OP_ADD, 1'b0, 16'h0000, 16'h0000, 40'h1, 6'h00);
      rdacc(1'b0, 40'h80_0000_0000);
      op(MAC_OP_LAC, 1'b1, 16'h0000, 16'h0000, 40'h01_0000_0000, 6'h00);
      op(MAC_OP_LAC, 1'b0, 16'h0000, 16'h0000, 40'h0, 6'h00);
      rd(OFS_STATUS, stat(40'h0, 40'h01_0000_0000, 1'b1, 1'b0));
      chk("trap_a", 40'h1, {32'h0, na});
      chk("trap_b", 40'h1, {32'h0, nb});
      chk("trap_cat", 40'h1, {32'h0, nc});
      chk("mul_left", 40'h0, 40'(mq.size()));
      wr(OFS_CORE, 16'h0091);
      op(MAC_OP_LAC, 1'b0, 16'h0000, 16'h0000, 40'h7F_FFFF_FFFF, 6'h00);
      op(MAC_OP_ADD, 1'b0, 16'h0000, 16'h0000, 40'h1, 6'h00);
      rdacc(1'b0, SAT39_POS);
      close_out();
   end
endmodule : mac_unit_bench
